// File: sor_regs.vh
// constants for spindle orientation input/output logic
`ifndef SOR_REGS_VH
`define SOR_REGS_VH
`define SOR_FN_ORIENT_REQ 8'h16
`define SOR_FN_DONE_POS 8'h1B
`define SOR_FN_DONE_NEG 8'h7F
`define SOR_FN_FAULT_POS 8'h1C
`define SOR_FN_FAULT_NEG 8'h80
`define SOR_INPOS_DEFAULT 8'h05
`define SOR_NUM_IN 12
`define SOR_NUM_OUT 7
`define SOR_POS_BITS 16
`define SOR_STOP_CYCLES 16'h2710
`define SOR_SYNC_SETTLE 3'h4
`define SOR_SEL_SPEED 7'h00
`endif

// File: sor_sync3.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module sor_sync3 #(
  parameter W = 1
) (
  input wire core_clk_i,
  input wire nrst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      s1_r <= {W{1'b0}};
      s2_r <= {W{1'b0}};
      s3_r <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_o <= (s2_r & s3_r) | (q_o & (s2_r | s3_r));
    end
  end
endmodule // sor_sync3

// File: sor_spindle_io.v
// spindle orientation encoder, command and terminal logic
`timescale 1ns/10ps
`include "sor_regs.vh"
module sor_spindle_io (
  input wire core_clk_i,
  input wire nrst_i,
  input wire enc_a_true_i,
  input wire enc_a_inverted_i,
  input wire enc_b_true_i,
  input wire enc_b_inverted_i,
  input wire enc_index_true_i,
  input wire enc_index_inverted_i,
  input wire [15:0] digital_cmd_word_i,
  input wire data_latch_gate_i,
  input wire latch_gate_used_i,
  input wire [6:0] command_word_select_i,
  input wire [`SOR_NUM_IN-1:0] input_terms_i,
  input wire [8*`SOR_NUM_IN-1:0] input_function_select_i,
  input wire [8*`SOR_NUM_OUT-1:0] output_function_select_i,
  input wire run_start_i,
  input wire [7:0] in_position_width_i,
  input wire [15:0] stop_target_i,
  output reg [15:0] speed_cmd_o,
  output reg [15:0] position_cmd_o,
  output reg [15:0] shaft_pos_o,
  output reg enc_pair_fault_o,
  output reg orient_request_o,
  output reg orient_done_o,
  output reg orient_fault_o,
  output reg [`SOR_NUM_OUT-1:0] output_terms_o
);
  // ==========================================
  // input synchronisation
  wire [5:0] enc_s;
  wire [`SOR_NUM_IN+17:0] ctl_s;
  sor_sync3 #(.W(6)) u_enc (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .d_i({enc_a_true_i, enc_a_inverted_i, enc_b_true_i, enc_b_inverted_i,
          enc_index_true_i, enc_index_inverted_i}),
    .q_o(enc_s)
  );
  sor_sync3 #(.W(`SOR_NUM_IN+18)) u_ctl (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .d_i({input_terms_i, run_start_i, data_latch_gate_i, digital_cmd_word_i}),
    .q_o(ctl_s)
  );
  wire enc_a = enc_s[5];
  wire enc_a_n = enc_s[4];
  wire enc_b = enc_s[3];
  wire enc_b_n = enc_s[2];
  wire enc_z = enc_s[1];
  wire enc_z_n = enc_s[0];
  wire [15:0] word_s = ctl_s[15:0];
  wire gate_s = ctl_s[16];
  wire run_s = ctl_s[17];
  wire [`SOR_NUM_IN-1:0] terms_s = ctl_s[`SOR_NUM_IN+17:18];
  // ==========================================
  // quadrature decode
  reg a_d_r;
  reg b_d_r;
  reg z_d_r;
  reg [15:0] stop_cnt_r;
  reg [15:0] pos_nxt;
  reg [15:0] stop_nxt;
  reg [2:0] settle_r;
  wire step = (enc_a ^ a_d_r) | (enc_b ^ b_d_r);
  wire dir_up = enc_a ^ b_d_r;
  wire index_rise = enc_z & ~z_d_r;
  wire pair_a_bad = (enc_a == enc_a_n);
  wire pair_b_bad = (enc_b == enc_b_n);
  wire pair_z_bad = (enc_z == enc_z_n);
  wire pair_bad = pair_a_bad | pair_b_bad | pair_z_bad;
  wire settled = (settle_r == `SOR_SYNC_SETTLE);
  wire stopped = (stop_cnt_r == `SOR_STOP_CYCLES);
  // ==========================================
  // synchroniser settle count
  // pairs read equal until the filters fill
  always @(posedge core_clk_i) begin
    if (!nrst_i)
      settle_r <= 3'h0;
    else if (!settled)
      settle_r <= settle_r + 3'h1;
  end
  // ==========================================
  // position and stop counter next values
  // quadrature and index
  always @* begin
    pos_nxt = shaft_pos_o;
    if (index_rise)
      pos_nxt = 16'h0000;
    else if (step && dir_up)
      pos_nxt = shaft_pos_o + 16'h0001;
    else if (step)
      pos_nxt = shaft_pos_o - 16'h0001;
  end
  always @* begin
    stop_nxt = stop_cnt_r;
    if (step)
      stop_nxt = 16'h0000;
    else if (!stopped)
      stop_nxt = stop_cnt_r + 16'h0001;
  end
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      a_d_r <= 1'b0;
      b_d_r <= 1'b0;
      z_d_r <= 1'b0;
      shaft_pos_o <= 16'h0000;
      stop_cnt_r <= 16'h0000;
      enc_pair_fault_o <= 1'b0;
    end else begin
      a_d_r <= enc_a;
      b_d_r <= enc_b;
      z_d_r <= enc_z;
      enc_pair_fault_o <= pair_bad & settled;
      shaft_pos_o <= pos_nxt;
      stop_cnt_r <= stop_nxt;
    end
  end
  // ==========================================
  // command word latch
  reg [15:0] word_r;
  wire sel_speed = (command_word_select_i == `SOR_SEL_SPEED);
  wire sample_en = !latch_gate_used_i | gate_s;
  always @(posedge core_clk_i) begin
    if (!nrst_i)
      word_r <= 16'h0000;
    else if (sample_en)
      word_r <= word_s;
  end
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      speed_cmd_o <= 16'h0000;
      position_cmd_o <= 16'h0000;
    end else if (sel_speed) begin
      speed_cmd_o <= word_r;
    end else begin
      position_cmd_o <= word_r;
    end
  end
  // ==========================================
  // orientation request routing
  wire [`SOR_NUM_IN-1:0] req_hit;
  genvar t;
  generate
    for (t = 0; t < `SOR_NUM_IN; t = t + 1) begin : g_req
      wire [7:0] in_fn = input_function_select_i[8*t +: 8];
      assign req_hit[t] = (in_fn == `SOR_FN_ORIENT_REQ) & terms_s[t];
    end
  endgenerate
  wire req_nxt = |req_hit;
  // ==========================================
  // in-position judgement
  reg [15:0] err_abs;
  reg in_zone;
  wire [15:0] err_raw = shaft_pos_o - stop_target_i;
  wire [15:0] zone_w = {8'h00, in_position_width_i};
  wire active = run_s & req_nxt;
  always @* begin
    err_abs = err_raw;
    if (err_raw[15])
      err_abs = 16'h0000 - err_raw;
    in_zone = (err_abs <= zone_w);
  end
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      orient_request_o <= 1'b0;
      orient_done_o <= 1'b0;
      orient_fault_o <= 1'b0;
    end else begin
      orient_request_o <= req_nxt;
      orient_done_o <= active & stopped & in_zone;
      orient_fault_o <= active & stopped & !in_zone;
    end
  end
  // ==========================================
  // output terminal mapping
  genvar g;
  generate
    for (g = 0; g < `SOR_NUM_OUT; g = g + 1) begin : g_out
      wire [7:0] fn = output_function_select_i[8*g +: 8];
      always @(posedge core_clk_i) begin
        if (!nrst_i) begin
          output_terms_o[g] <= 1'b0;
        end else begin
          case (fn)
            `SOR_FN_DONE_POS: output_terms_o[g] <= orient_done_o;
            `SOR_FN_DONE_NEG: output_terms_o[g] <= !orient_done_o;
            `SOR_FN_FAULT_POS: output_terms_o[g] <= orient_fault_o;
            `SOR_FN_FAULT_NEG: output_terms_o[g] <= !orient_fault_o;
            default: output_terms_o[g] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate
endmodule // sor_spindle_io

// File: sor_spindle_io_properties.sv
// port checker for spindle orientation logic
`timescale 1ns/10ps
module sor_props (input wire core_clk_i, nrst_i, enc_a_true_i, enc_a_inverted_i,
  data_latch_gate_i, latch_gate_used_i, run_start_i, enc_pair_fault_o, orient_request_o,
  orient_done_o, orient_fault_o, input wire [6:0] command_word_select_i, output_terms_o,
  input wire [11:0] input_terms_i, input wire [55:0] output_function_select_i,
  input wire [7:0] in_position_width_i, input wire [15:0] stop_target_i, speed_cmd_o,
  position_cmd_o, shaft_pos_o);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  wire [7:0] f0 = output_function_select_i[7:0];
  wire [7:0] f1 = output_function_select_i[15:8];
  wire [15:0] dp = shaft_pos_o - stop_target_i;
  wire [15:0] dn = stop_target_i - shaft_pos_o;
  sequence s_gate_shut;
    (latch_gate_used_i && !data_latch_gate_i) [*8];
  endsequence
  a_done_xor_fault: assert property (!(orient_done_o && orient_fault_o))
    else $error("done and fault together");
  a_done_term: assert property ($past(nrst_i) && (f0 == 8'h1B || f0 == 8'h7F) && $stable(f0)
    |-> output_terms_o[0] == ($past(orient_done_o) ^ (f0 == 8'h7F))) else $error("done pin");
  a_fault_term: assert property ($past(nrst_i) && (f1 == 8'h1C || f1 == 8'h80) && $stable(f1)
    |-> output_terms_o[1] == ($past(orient_fault_o) ^ (f1 == 8'h80))) else $error("fault pin");
  a_unused_out: assert property (output_function_select_i[55:16] == 0
    |-> output_terms_o[6:2] == 0) else $error("unmapped pin driven");
  a_cmd_hold: assert property (s_gate_shut |=> $stable(speed_cmd_o) && $stable(position_cmd_o))
    else $error("word moved with gate shut");
  a_spd_hold: assert property (command_word_select_i != 0 [*8] |=> $stable(speed_cmd_o))
    else $error("speed moved");
  a_pos_hold: assert property (command_word_select_i == 0 [*8] |=> $stable(position_cmd_o))
    else $error("position moved");
  a_idle_out: assert property (!run_start_i [*8] |-> !orient_done_o && !orient_fault_o)
    else $error("status without run");
  a_req_map: assert property (input_terms_i == 0 [*8] |-> !orient_request_o)
    else $error("request without terminal");
  a_pair_bad: assert property ((enc_a_true_i == enc_a_inverted_i) [*8] |-> enc_pair_fault_o)
    else $error("pair fault missed");
  a_zone_done: assert property (orient_done_o && $stable(shaft_pos_o)
    && $past(stop_target_i, 3) == stop_target_i
    |-> dp <= in_position_width_i || dn <= in_position_width_i) else $error("done off zone");
endmodule // sor_props
bind sor_spindle_io sor_props u_props (.*);

// File: sor_enc_model.sv
// shaft encoder model with line pairs
`timescale 1ns/10ps
module sor_enc_model (input wire core_clk_i, step_i, break_i, output wire enc_a_true_o,
  enc_a_inverted_o, enc_b_true_o, enc_b_inverted_o, enc_index_true_o, enc_index_inverted_o);
  reg [3:0] pos_r = 4'h0;
  always @(posedge core_clk_i) if (step_i) pos_r <= pos_r + 4'h1;
  assign enc_a_true_o = pos_r[0] ^ pos_r[1];
  assign enc_b_true_o = pos_r[1];
  assign enc_index_true_o = pos_r == 4'h0;
  assign enc_a_inverted_o = break_i ~^ enc_a_true_o;
  assign enc_b_inverted_o = !enc_b_true_o;
  assign enc_index_inverted_o = !enc_index_true_o;
endmodule // sor_enc_model

// File: tb_top.sv
// testbench for spindle orientation logic
`timescale 1ns/10ps
module tb_top;
  reg clk = 0, rst_n = 0, step = 0, brk = 0, gate = 1, run = 0;
  reg [15:0] word = 16'h0000, tgt = 16'h000A, held;
  reg [6:0] sel = 7'h00;
  reg lgu = 1;
  reg [7:0] wdt = 8'h05;
  reg [11:0] terms = 12'h000;
  reg [55:0] ofs = {40'h0, 8'h1C, 8'h1B};
  integer n_errors = 0, check_count = 0, cyc = 0, seed = 32'hdba184d3, pos = 0, i;
  wire a, an, b, bn, z, zn, pf, rq, dn, ft;
  wire [15:0] spd, psn, shp;
  wire [6:0] ot;
  initial forever #10 clk = ~clk;
  sor_spindle_io dut (.core_clk_i(clk), .nrst_i(rst_n), .enc_a_true_i(a), .enc_a_inverted_i(an),
    .enc_b_true_i(b), .enc_b_inverted_i(bn), .enc_index_true_i(z), .enc_index_inverted_i(zn),
    .digital_cmd_word_i(word), .data_latch_gate_i(gate), .latch_gate_used_i(lgu),
    .command_word_select_i(sel), .input_terms_i(terms),
    .input_function_select_i({64'h0, 8'h16, 24'h0}), .output_function_select_i(ofs),
    .run_start_i(run), .in_position_width_i(wdt), .stop_target_i(tgt), .speed_cmd_o(spd),
    .position_cmd_o(psn), .shaft_pos_o(shp), .enc_pair_fault_o(pf), .orient_request_o(rq),
    .orient_done_o(dn), .orient_fault_o(ft), .output_terms_o(ot));
  sor_enc_model enc (.core_clk_i(clk), .step_i(step), .break_i(brk), .enc_a_true_o(a),
    .enc_a_inverted_o(an), .enc_b_true_o(b), .enc_b_inverted_o(bn), .enc_index_true_o(z),
    .enc_index_inverted_o(zn));
  task chk(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_errors = n_errors + 1;
      test_done;
    end
  end
  initial begin
    tick(5);
    rst_n = 1;
    tick(1);
    chk({pf, rq, dn, ft, 5'h0, ot}, 16'h0000);
    for (i = 0; i < 5; i = i + 1) begin
      step = 1;
      tick(1);
      step = 0;
      tick(5);
      pos = pos + 1;
    end
    tick(8);
    chk(shp, pos[15:0]);
    word = 16'($random(seed));
    held = word;
    tick(10);
    chk(spd, held);
    gate = 0;
    tick(8);
    word = ~held;
    tick(10);
    chk(spd, held);
    sel = 7'h01;
    gate = 1;
    tick(10);
    chk(psn, word);
    chk(spd, held);
    terms = 12'h008;
    run = 1;
    tick(10010);
    chk({11'h0, rq, dn, ft, ot[1:0]}, 16'h0019);
    tgt = 16'h000B;
    tick(10);
    chk({11'h0, rq, dn, ft, ot[1:0]}, 16'h0016);
    ofs = {40'h0, 8'h80, 8'h7F};
    tick(3);
    chk({11'h0, rq, dn, ft, ot[1:0]}, 16'h0015);
    run = 0;
    tick(10);
    chk({11'h0, rq, dn, ft, ot[1:0]}, 16'h0013);
    lgu = 0;
    gate = 0;
    word = held;
    tick(10);
    chk(psn, held);
    brk = 1;
    tick(10);
    chk({15'h0, pf}, 16'h0001);
    run = 1;
    wdt = 8'h06;
    tick(10);
    chk({11'h0, rq, dn, ft, ot[1:0]}, 16'h001A);
    test_done;
  end
endmodule // tb_top
